// ==== hdl/hmwr_pkg.sv ====
// constants and types for the high-speed write receiver
package hmwr_pkg;

  // ************************************************************
  // bus addressing
  // ************************************************************
  localparam logic [4:0] DEV_ADDR_PREFIX = 5'h13;
  localparam logic [4:0] HS_CODE_PREFIX  = 5'h01;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
  localparam logic [1:0] LOAD_TEMP_OUT   = 2'h1;

  // ************************************************************
  // register map and reset values
  // ************************************************************
  localparam int         AXI_ADDR_W      = 8;
  localparam logic [7:0] REG_STATUS      = 8'h00;
  localparam logic [7:0] REG_CONTROL     = 8'h04;
  localparam logic [7:0] REG_WORDS       = 8'h08;
  localparam logic [3:0] REG_TEMP_PAGE   = 4'h1;
  localparam logic [3:0] REG_OUT_PAGE    = 4'h2;
  localparam logic       ENABLE_RESET    = 1'b1;
  localparam logic [13:0] CHAN_RESET     = 14'h0000;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  // ************************************************************
  // state types
  // ************************************************************
  typedef enum logic [2:0] {
    ph_idle, ph_addr, ph_ctrl, ph_hi, ph_lo, ph_pd1, ph_pd2, ph_skip
  } hmwr_phase_type;

  typedef enum logic [1:0] {rd_idle, rd_mem, rd_load, rd_resp} hmwr_rd_type;

endpackage : hmwr_pkg

// ==== hdl/hmwr_chan_mem.sv ====
// per-channel temporary and output registers
`timescale 1ns/1ns
`default_nettype none
module hmwr_chan_mem
  import hmwr_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         copy_all,
  input  wire logic         wr_en,
  input  wire logic [1:0]   wr_ch,
  input  wire logic         wr_pd,
  input  wire logic         wr_out,
  input  wire logic [13:0]  wr_data,
  input  wire logic [2:0]   rd_sel,
  output logic      [13:0]  rd_data,
  output logic      [55:0]  dac_code
);

  typedef struct packed {
    logic [3:0][13:0] tmp;
    logic [3:0][13:0] outr;
    logic [13:0]      rd;
  } hmwr_mem_type;

  hmwr_mem_type s;
  hmwr_mem_type n;

  // ************************************************************
  // storage update
  // ************************************************************
  always_comb begin
    n = s;
    if (copy_all) begin
      n.outr = s.tmp;
    end
    if (wr_en) begin
      if (wr_pd) begin
        n.tmp[wr_ch][13:12] = wr_data[13:12];
      end else begin
        n.tmp[wr_ch][11:0] = wr_data[11:0];
      end
      if (wr_out) begin
        n.outr[wr_ch] = n.tmp[wr_ch];
      end
    end
    n.rd = rd_sel[2] ? s.outr[rd_sel[1:0]] : s.tmp[rd_sel[1:0]];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '{tmp: {4{CHAN_RESET}}, outr: {4{CHAN_RESET}}, rd: CHAN_RESET};
    end else begin
      s <= n;
    end
  end

  assign rd_data  = s.rd;
  assign dac_code = s.outr;

endmodule : hmwr_chan_mem
`default_nettype wire

// ==== hdl/hmwr_top.sv ====
// high-speed two-wire write receiver with axi4-lite register access
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - the high-speed code byte is never acknowledged, the data line stays released.
// - a matching write address with the two strap bits is acknowledged by pulling data low.
// - the control byte after the address is acknowledged as well.
// - control byte holds zero, zero, load mode, zero, channel select and power-down select.
// - with power-down select clear, high/low data pairs are taken and acked until stop or restart.
// - a word is twelve bits, eight from the high byte and four from the low byte upper nibble.
// - with power-down select set exactly two further bytes are taken and acked.
// - each channel keeps a 14-bit temporary and output register, top two bits power-down.
module hmwr_top
  import hmwr_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe_n,
  input  wire logic                  address_pin_bit_hi,
  input  wire logic                  address_pin_bit_lo,
  output logic                       hs_active,
  output logic      [55:0]           dac_code,
  input  wire logic [AXI_ADDR_W-1:0] awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic      [1:0]            bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [AXI_ADDR_W-1:0] araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic      [31:0]           rdata,
  output logic      [1:0]            rresp,
  output logic                       rvalid,
  input  wire logic                  rready
);

  typedef struct packed {
    logic                  scl_s1;
    logic                  scl_s2;
    logic                  scl_d;
    logic                  sda_s1;
    logic                  sda_s2;
    logic                  sda_d;
    logic                  a1_s1;
    logic                  a1_s2;
    logic                  a0_s1;
    logic                  a0_s2;
    hmwr_phase_type        phase;
    logic [3:0]            bit_cnt;
    logic [7:0]            shift;
    logic                  byte_done;
    logic                  ack_phase;
    logic                  sda_oe_n;
    logic                  sda_out;
    logic                  hs_mode;
    logic [7:0]            ctrl;
    logic [7:0]            hi;
    logic                  ctrl_error;
    logic [15:0]           words;
    logic                  wr_en;
    logic                  wr_pd;
    logic                  wr_out;
    logic [13:0]           wr_data;
    logic                  copy_all;
    logic                  enable;
    logic                  awready;
    logic                  wready;
    logic [AXI_ADDR_W-1:0] waddr;
    logic [31:0]           wdata;
    logic                  wstrb0;
    logic                  bvalid;
    logic [1:0]            bresp;
    hmwr_rd_type           rd;
    logic                  arready;
    logic [AXI_ADDR_W-1:0] raddr;
    logic [2:0]            rd_sel;
    logic                  rvalid;
    logic [1:0]            rresp;
    logic [31:0]           rdata;
  } hmwr_state_type;

  hmwr_state_type s;
  hmwr_state_type n;
  logic [13:0]    mem_rd;
  logic           scl_rise;
  logic           scl_fall;
  logic           i2c_start;
  logic           i2c_stop;
  logic           active;
  logic           decide;
  logic [7:0]     own_addr;

  // ************************************************************
  // bus condition detection
  // ************************************************************
  assign scl_rise  = s.scl_s2 && !s.scl_d;
  assign scl_fall  = !s.scl_s2 && s.scl_d;
  assign i2c_start = s.scl_s2 && s.scl_d && !s.sda_s2 && s.sda_d;
  assign i2c_stop  = s.scl_s2 && s.scl_d && s.sda_s2 && !s.sda_d;
  assign active    = !i2c_start && !i2c_stop && (s.phase != ph_idle);
  assign decide    = active && scl_fall && s.byte_done && !s.ack_phase;
  assign own_addr  = {DEV_ADDR_PREFIX, s.a1_s2, s.a0_s2, 1'b0};

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic ack;
    ack = 1'b0;
    n = s;
    n.scl_s1   = scl_in;
    n.scl_s2   = s.scl_s1;
    n.scl_d    = s.scl_s2;
    n.sda_s1   = sda_in;
    n.sda_s2   = s.sda_s1;
    n.sda_d    = s.sda_s2;
    n.a1_s1    = address_pin_bit_hi;
    n.a1_s2    = s.a1_s1;
    n.a0_s1    = address_pin_bit_lo;
    n.a0_s2    = s.a0_s1;
    n.wr_en    = 1'b0;
    n.copy_all = 1'b0;

    // axi write channels
    if (s.awready && awvalid) begin
      n.awready = 1'b0;
      n.waddr   = awaddr;
    end
    if (s.wready && wvalid) begin
      n.wready = 1'b0;
      n.wdata  = wdata;
      n.wstrb0 = wstrb[0];
    end
    if (!s.awready && !s.wready && !s.bvalid) begin
      n.bvalid = 1'b1;
      n.bresp  = RESP_OKAY;
      if (s.waddr == REG_CONTROL) begin
        if (s.wstrb0) begin
          n.enable   = s.wdata[0];
          n.copy_all = s.wdata[1];
          if (s.wdata[2]) begin
            n.ctrl_error = 1'b0;
          end
        end
      end else begin
        n.bresp = RESP_SLVERR;
      end
    end
    if (s.bvalid && bready) begin
      n.bvalid  = 1'b0;
      n.awready = 1'b1;
      n.wready  = 1'b1;
    end

    // axi read channels
    case (s.rd)
      rd_idle: begin
        if (arvalid && s.arready) begin
          n.arready = 1'b0;
          n.raddr   = araddr;
          n.rd_sel  = {araddr[5], araddr[3:2]};
          n.rd      = rd_mem;
        end
      end
      rd_mem: begin
        n.rd = rd_load;
      end
      rd_load: begin
        n.rvalid = 1'b1;
        n.rresp  = RESP_OKAY;
        n.rd     = rd_resp;
        if (s.raddr == REG_STATUS) begin
          n.rdata = {16'h0000, s.ctrl, 5'h00, s.ctrl_error, s.phase != ph_idle, s.hs_mode};
        end else if (s.raddr == REG_CONTROL) begin
          n.rdata = {31'h00000000, s.enable};
        end else if (s.raddr == REG_WORDS) begin
          n.rdata = {16'h0000, s.words};
        end else if ((s.raddr[7:4] == REG_TEMP_PAGE || s.raddr[7:4] == REG_OUT_PAGE)
                     && s.raddr[1:0] == 2'h0) begin
          n.rdata = {18'h00000, mem_rd};
        end else begin
          n.rdata = 32'h00000000;
          n.rresp = RESP_SLVERR;
        end
      end
      rd_resp: begin
        if (rready) begin
          n.rvalid  = 1'b0;
          n.arready = 1'b1;
          n.rd      = rd_idle;
        end
      end
      default: begin
        n.rd = rd_idle;
      end
    endcase

    // two-wire receiver
    if (i2c_stop) begin
      n.phase     = ph_idle;
      n.hs_mode   = 1'b0;
      n.sda_oe_n  = 1'b1;
      n.ack_phase = 1'b0;
      n.byte_done = 1'b0;
    end else if (i2c_start) begin
      n.phase     = ph_addr;
      n.bit_cnt   = 4'h0;
      n.byte_done = 1'b0;
      n.ack_phase = 1'b0;
      n.sda_oe_n  = 1'b1;
    end else if (active) begin
      if (scl_rise && !s.ack_phase && !s.byte_done) begin
        n.shift   = {s.shift[6:0], s.sda_s2};
        n.bit_cnt = s.bit_cnt + 4'h1;
        if (s.bit_cnt == BITS_PER_BYTE - 4'h1) begin
          n.byte_done = 1'b1;
        end
      end else if (scl_fall && s.ack_phase) begin
        n.ack_phase = 1'b0;
        n.sda_oe_n  = 1'b1;
      end else if (decide) begin
        n.byte_done = 1'b0;
        n.bit_cnt   = 4'h0;
        n.ack_phase = 1'b1;
        case (s.phase)
          ph_addr: begin
            if (s.shift[7:3] == HS_CODE_PREFIX) begin
              n.hs_mode = 1'b1;
              n.phase   = ph_skip;
            end else if (s.enable && s.shift == own_addr) begin
              ack     = 1'b1;
              n.phase = ph_ctrl;
            end else begin
              n.phase = ph_skip;
            end
          end
          ph_ctrl: begin
            ack     = 1'b1;
            n.ctrl  = s.shift;
            n.phase = s.shift[0] ? ph_pd1 : ph_hi;
            if (s.shift[7:6] != 2'h0 || s.shift[3]) begin
              n.ctrl_error = 1'b1;
            end
          end
          ph_hi: begin
            ack     = 1'b1;
            n.hi    = s.shift;
            n.phase = ph_lo;
          end
          ph_lo: begin
            ack       = 1'b1;
            n.wr_en   = 1'b1;
            n.wr_pd   = 1'b0;
            n.wr_data = {2'h0, s.hi, s.shift[7:4]};
            n.wr_out  = s.ctrl[5:4] == LOAD_TEMP_OUT;
            n.words   = s.words + 16'h0001;
            n.phase   = ph_hi;
          end
          ph_pd1: begin
            ack     = 1'b1;
            n.hi    = s.shift;
            n.phase = ph_pd2;
          end
          ph_pd2: begin
            ack       = 1'b1;
            n.wr_en   = 1'b1;
            n.wr_pd   = 1'b1;
            n.wr_data = {s.hi[7:6], 12'h000};
            n.wr_out  = s.ctrl[5:4] == LOAD_TEMP_OUT;
            n.phase   = ph_skip;
          end
          default: begin
            n.phase = ph_skip;
          end
        endcase
        n.sda_oe_n = !ack;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s          <= '0;
      s.scl_s1   <= 1'b1;
      s.scl_s2   <= 1'b1;
      s.scl_d    <= 1'b1;
      s.sda_s1   <= 1'b1;
      s.sda_s2   <= 1'b1;
      s.sda_d    <= 1'b1;
      s.phase    <= ph_idle;
      s.rd       <= rd_idle;
      s.sda_oe_n <= 1'b1;
      s.enable   <= ENABLE_RESET;
      s.awready  <= 1'b1;
      s.wready   <= 1'b1;
      s.arready  <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ************************************************************
  // channel storage
  // ************************************************************
  hmwr_chan_mem u_mem (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .copy_all (s.copy_all),
    .wr_en    (s.wr_en),
    .wr_ch    (s.ctrl[2:1]),
    .wr_pd    (s.wr_pd),
    .wr_out   (s.wr_out),
    .wr_data  (s.wr_data),
    .rd_sel   (s.rd_sel),
    .rd_data  (mem_rd),
    .dac_code (dac_code)
  );

  assign sda_out   = s.sda_out;
  assign sda_oe_n  = s.sda_oe_n;
  assign hs_active = s.hs_mode;
  assign awready   = s.awready;
  assign wready    = s.wready;
  assign bvalid    = s.bvalid;
  assign bresp     = s.bresp;
  assign arready   = s.arready;
  assign rvalid    = s.rvalid;
  assign rresp     = s.rresp;
  assign rdata     = s.rdata;

  // ************************************************************
  // assertions
  // ************************************************************
  a_hs_code_nak: assert property (
    @(posedge aclk) disable iff (!aresetn)
    decide && s.phase == ph_addr && s.shift[7:3] == HS_CODE_PREFIX
    |=> sda_oe_n && hs_active && s.ack_phase)
    else $error("high-speed code was acknowledged");

  a_addr_ack: assert property (
    @(posedge aclk) disable iff (!aresetn)
    decide && s.phase == ph_addr && s.enable && s.shift == own_addr
    |=> !sda_oe_n && s.phase == ph_ctrl)
    else $error("own write address not acknowledged");

  a_ack_held: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s.ack_phase && !sda_oe_n |=> !sda_oe_n || !s.ack_phase)
    else $error("acknowledge released early");

  a_ctrl_ack: assert property (
    @(posedge aclk) disable iff (!aresetn)
    decide && s.phase == ph_ctrl |=> !sda_oe_n ##1 s.ctrl == $past(s.shift, 2))
    else $error("control byte not acknowledged or stored");

  a_ctrl_route: assert property (
    @(posedge aclk) disable iff (!aresetn)
    decide && s.phase == ph_ctrl
    |=> s.phase == ($past(s.shift[0]) ? ph_pd1 : ph_hi))
    else $error("power-down select misrouted");

  a_pair_loop: assert property (
    @(posedge aclk) disable iff (!aresetn)
    decide && s.phase == ph_lo |=> !sda_oe_n && s.phase == ph_hi && s.wr_en)
    else $error("data pair not accepted");

  a_word_pack: assert property (
    @(posedge aclk) disable iff (!aresetn)
    decide && s.phase == ph_lo
    |=> s.wr_data[11:0] == {$past(s.hi), $past(s.shift[7:4])} && !s.wr_pd)
    else $error("data word packed wrong");

  a_pd_two_bytes: assert property (
    @(posedge aclk) disable iff (!aresetn)
    decide && s.phase == ph_pd2 |=> !sda_oe_n && s.phase == ph_skip && s.wr_pd)
    else $error("power-down word not closed after two bytes");

  a_skip_nak: assert property (
    @(posedge aclk) disable iff (!aresetn)
    decide && s.phase == ph_skip |=> sda_oe_n [*2])
    else $error("extra byte acknowledged");

  a_pd_store: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s.wr_en && s.wr_pd && s.wr_out
    |=> dac_code[(6'(s.ctrl[2:1]) * 6'd14) + 6'd12 +: 2] == $past(s.wr_data[13:12]))
    else $error("power-down bits not stored in output register");

  a_stop_exit: assert property (
    @(posedge aclk) disable iff (!aresetn)
    i2c_stop |=> !hs_active && s.phase == ph_idle && sda_oe_n)
    else $error("stop did not leave high-speed mode");

endmodule : hmwr_top
`default_nettype wire

// ==== bench/hmwr_master_model.sv ====
// two-wire bus master model driving the write receiver
`timescale 1ns/1ns
`default_nettype none
module hmwr_master_model (
  input  wire logic aclk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_pull
);
  // ************************************************************
  // bus timing, one bit is 20 aclk, clock idles high
  // ************************************************************
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic wait_c(input int n);
    repeat (n) @(posedge aclk);
  endtask : wait_c
  // start or repeated start, clock left low
  task automatic start_cond();
    sda_pull <= 1'b0;
    wait_c(5);
    scl <= 1'b1;
    wait_c(5);
    sda_pull <= 1'b1;
    wait_c(5);
    scl <= 1'b0;
    wait_c(5);
  endtask : start_cond
  task automatic clk_bit(input logic b, output logic s);
    sda_pull <= ~b;
    wait_c(5);
    scl <= 1'b1;
    wait_c(5);
    s = sda;
    wait_c(5);
    scl <= 1'b0;
    wait_c(5);
  endtask : clk_bit
  // msb first, line released in the ninth clock
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, s);
    ack = ~s;
  endtask : send_byte
  task automatic stop_cond();
    sda_pull <= 1'b1;
    wait_c(5);
    scl <= 1'b1;
    wait_c(5);
    sda_pull <= 1'b0;
    wait_c(10);
  endtask : stop_cond
endmodule : hmwr_master_model
`default_nettype wire

// ==== bench/hs_mode_write_receiver_tb_top.sv ====
// self-checking testbench for the high-speed write receiver
`timescale 1ns/1ns
`default_nettype none
module hs_mode_write_receiver_tb_top;
  import hmwr_pkg::*;
  logic        aclk, aresetn, scl, mst_pull, sda_out, sda_oe_n, hs_active;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, ack;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  logic [55:0] dac_code;
  wire         sda;
  int          error_cnt, n_checks;
  logic [1:0]  strap;
  logic [3:0]  wstrb_r;
  localparam logic [7:0] MY_ADDR = {DEV_ADDR_PREFIX, 2'b10, 1'b0};
  assign sda = (mst_pull || (!sda_oe_n && !sda_out)) ? 1'b0 : 1'b1;
  hmwr_master_model mst_u (.aclk(aclk), .sda(sda), .scl(scl), .sda_pull(mst_pull));
  hmwr_top dut_u (
    .aclk(aclk), .aresetn(aresetn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .address_pin_bit_hi(strap[1]), .address_pin_bit_lo(strap[0]),
    .hs_active(hs_active), .dac_code(dac_code), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb_r), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    r = bresp;
    bready <= 1'b0;
    check("write answer in time", n < 100, 1'b1);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    check("read answer in time", n < 100, 1'b1);
  endtask : axi_rd
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    axi_rd(REG_STATUS, rd, rs);
    check("status after reset", rd, 32'h0);
    axi_rd(REG_CONTROL, rd, rs);
    check("control after reset", rd, {31'h0, ENABLE_RESET});
    axi_rd(8'h30, rd, rs);
    check("unmapped read data", rd, 32'h0);
    check("unmapped read resp", rs, RESP_SLVERR);
    axi_wr(REG_STATUS, 32'hffff_ffff, rs);
    check("read-only write resp", rs, RESP_SLVERR);
    wstrb_r <= 4'he;
    axi_wr(REG_CONTROL, 32'h0, rs);
    wstrb_r <= 4'hf;
    check("masked control write resp", rs, RESP_OKAY);
    axi_rd(REG_CONTROL, rd, rs);
    check("masked control write kept", rd, {31'h0, ENABLE_RESET});
    check("outputs after reset", dac_code[31:0], 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_hs_write();
    mst_u.start_cond();
    mst_u.send_byte({HS_CODE_PREFIX, 3'h5}, ack);
    check("code byte ack", ack, 1'b0);
    check("high speed flag", hs_active, 1'b1);
    mst_u.start_cond();
    mst_u.send_byte(MY_ADDR, ack);
    check("address ack", ack, 1'b1);
    mst_u.send_byte(8'h12, ack);
    check("control ack", ack, 1'b1);
    mst_u.send_byte(8'hab, ack);
    check("high byte ack", ack, 1'b1);
    mst_u.send_byte(8'hc5, ack);
    check("low byte ack", ack, 1'b1);
    check("ch1 first word", dac_code[27:14], 14'h0abc);
    mst_u.send_byte(8'h12, ack);
    mst_u.send_byte(8'h3f, ack);
    check("second pair ack", ack, 1'b1);
    check("ch1 second word", dac_code[27:14], 14'h0123);
    check("ch0 untouched", dac_code[13:0], 14'h0);
    mst_u.start_cond();
    mst_u.send_byte(MY_ADDR, ack);
    check("address ack after restart", ack, 1'b1);
    mst_u.send_byte(8'h15, ack);
    check("pd control ack", ack, 1'b1);
    mst_u.send_byte(8'h80, ack);
    check("pd byte one ack", ack, 1'b1);
    mst_u.send_byte(8'h00, ack);
    check("pd byte two ack", ack, 1'b1);
    check("ch2 power-down bits", dac_code[41:28], 14'h2000);
    mst_u.send_byte(8'h00, ack);
    check("extra pd byte refused", ack, 1'b0);
    check("still high speed", hs_active, 1'b1);
    axi_rd(REG_STATUS, rd, rs);
    check("status in transfer", rd, 32'h0000_1503);
    mst_u.stop_cond();
    check("high speed left on stop", hs_active, 1'b0);
    $display("test hs write done");
  endtask : t_hs_write
  task automatic t_refuse();
    mst_u.start_cond();
    mst_u.send_byte(8'h98, ack);
    check("wrong strap ack", ack, 1'b0);
    strap <= 2'b00;
    mst_u.start_cond();
    mst_u.send_byte(8'h98, ack);
    check("other strap ack", ack, 1'b1);
    strap <= 2'b10;
    mst_u.start_cond();
    mst_u.send_byte(MY_ADDR | 8'h01, ack);
    check("read direction ack", ack, 1'b0);
    mst_u.stop_cond();
    axi_wr(REG_CONTROL, 32'h0, rs);
    mst_u.start_cond();
    mst_u.send_byte(MY_ADDR, ack);
    check("disabled address ack", ack, 1'b0);
    mst_u.stop_cond();
    axi_wr(REG_CONTROL, 32'h1, rs);
    check("control write resp", rs, RESP_OKAY);
    mst_u.start_cond();
    mst_u.send_byte(MY_ADDR, ack);
    mst_u.send_byte(8'h08, ack);
    check("flagged control ack", ack, 1'b1);
    mst_u.send_byte(8'h5a, ack);
    mst_u.send_byte(8'h60, ack);
    check("temp-only low ack", ack, 1'b1);
    mst_u.stop_cond();
    check("output held", dac_code[13:0], 14'h0);
    axi_rd(8'h10, rd, rs);
    check("ch0 temp register", rd, 32'h5a6);
    axi_rd(REG_STATUS, rd, rs);
    check("status control error", rd, 32'h0000_0804);
    axi_rd(REG_WORDS, rd, rs);
    check("data word count", rd, 32'h3);
    axi_wr(REG_CONTROL, 32'h7, rs);
    repeat (2) @(posedge aclk);
    check("ch0 after copy", dac_code[13:0], 14'h05a6);
    axi_rd(REG_STATUS, rd, rs);
    check("status error cleared", rd, 32'h0000_0800);
    $display("test refuse done");
  endtask : t_refuse
  // ************************************************************
  // clock, reset, sequence, watchdog
  // ************************************************************
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  initial begin
    #500000;
    error_cnt++;
    final_report();
  end
  initial begin
    error_cnt = 0;
    n_checks = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    strap = 2'b10;
    wstrb_r = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    t_reset();
    t_hs_write();
    t_refuse();
    final_report();
  end
endmodule : hs_mode_write_receiver_tb_top
`default_nettype wire
